// ===== src/irq_security_group.sv
/*
  Security-group configuration of a multi-PE interrupt controller: global
  group enables, group assignment, non-secure grants, redistributor wake and
  CPU-interface enables, driving one fast and one normal request per PE.
  Assumes an AXI4-Lite master on core_clk, awprot[1]/arprot[1] high for a
  non-secure access, PE state inputs on core_clk, source lines asynchronous.
*/
// Function
// - current-state group 1 at EL0/1 is normal
// - other-state group 1 is fast request
// - group 0 always fast request
// - group assignment writable only when secure
// - non-secure reaches secure interrupts only if granted
// - message interrupts always non-secure group 1
// - disable bit selects one or two states
// - single-state build: disable bit reads one
// - single state gives groups 0 and 1
// - disable bit sticky until reset
// - global registers for enables, priority, routing, trigger, pending
// - one redistributor per PE, one CPU interface
// - affinity routing enables per security state
// - three independent distribution group enables
// - disabled group never signalled
// - PE sleeping after reset
// - wake: clear sleep, poll children asleep
// - forward only above priority mask; binary point
// - completion mode bits for EL1 and EL3
// - per-group signalling enables in CPU interface
// - group 1 signalling enable banked by state
`timescale 1ns/10ps
`default_nettype none
module irq_security_group
  import irq_security_group_pkg::*;
#(
  parameter bit TWO_STATES = 1'b1
) (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire logic [NUM_INT-1:0]  intSource,
  input  wire logic [NUM_PE-1:0]   lpiRequest,
  input  wire logic [NUM_PE-1:0]   peSecure,
  input  wire logic [2*NUM_PE-1:0] peLevel,
  output logic [NUM_PE-1:0]        fastIrq,
  output logic [NUM_PE-1:0]        normalIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Address hits a register
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic pe;
    pe = (a[11:8] == PE_REGION) && (a[7:PE_STRIDE_LSB+PE_IDX_W] == '0);
    return pe || (a == OFF_GLOBAL_CTRL) || (a == OFF_GROUP) || (a == OFF_GROUP_MOD)
      || (a == OFF_NS_ACCESS) || (a == OFF_ENABLE) || (a == OFF_PENDING)
      || (a == OFF_TRIGGER) || (a == OFF_ROUTE) || (a == OFF_PRIO0) || (a == OFF_PRIO1);
  endfunction

  // Byte strobes to bit mask
  function automatic logic [31:0] strbMask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // One bit per interrupt widened to a priority field
  function automatic logic [31:0] expandPrio(input logic [INT_PER_WORD-1:0] m);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < INT_PER_WORD; k++) begin
      r[k*PRIO_W +: PRIO_W] = {PRIO_W{m[k]}};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  glbl_ctrl_s            gctl;
  pe_cfg_s               peCfg [NUM_PE];
  logic [NUM_INT-1:0]    groupBits;
  logic [NUM_INT-1:0]    groupMod;
  logic [NUM_INT-1:0]    nsAccess;
  logic [NUM_INT-1:0]    enableBits;
  logic [NUM_INT-1:0]    edgePend;
  logic [NUM_INT-1:0]    trigEdge;
  logic [NUM_INT-1:0]    routeBits;
  logic [NUM_INT*PRIO_W-1:0] prioBits;
  logic [NUM_INT-1:0]    srcMeta;
  logic [NUM_INT-1:0]    srcSync;
  logic [NUM_INT-1:0]    srcPrev;
  logic [ADDR_W-1:0]     wrAddr;
  logic [2:0]            wrProt;
  logic [31:0]           wrData;
  logic [3:0]            wrStrb;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  wire logic                 singleState = gctl.securityDisable;
  wire logic [NUM_INT-1:0]   secureInt   = ~groupBits | (groupBits & groupMod);
  wire logic                 wrFire      = ~awready & ~wready & ~bvalid;
  wire logic                 wrSecure    = ~wrProt[1] | singleState;
  wire logic                 rdSecure    = ~arprot[1] | singleState;
  wire logic [31:0]          wrByteMask  = strbMask(wrStrb);
  wire logic [NUM_INT-1:0]   wrGrant     = {NUM_INT{wrSecure}} | ~secureInt | nsAccess;
  wire logic [NUM_INT-1:0]   rdGrant     = {NUM_INT{rdSecure}} | ~secureInt | nsAccess;
  wire logic [NUM_INT-1:0]   wrIntMask   = wrByteMask[NUM_INT-1:0] & wrGrant;
  wire logic [NUM_INT-1:0]   wrSecMask   = wrByteMask[NUM_INT-1:0] & {NUM_INT{wrSecure}};
  wire logic                 wrMapped    = isMapped(wrAddr);
  wire logic                 wrPeRegion  = wrAddr[11:8] == PE_REGION;
  wire logic [PE_IDX_W-1:0]  wrPeIdx     = wrAddr[PE_STRIDE_LSB +: PE_IDX_W];
  wire logic [4:0]           wrPeOff     = wrAddr[4:0];
  wire logic                 wrPrioHi    = wrAddr == OFF_PRIO1;
  wire logic                 wrPrioSel   = (wrAddr == OFF_PRIO0) || wrPrioHi;
  wire logic [INT_PER_WORD-1:0] wrPrioGrant = wrPrioHi ? wrGrant[NUM_INT-1:INT_PER_WORD]
                                                      : wrGrant[INT_PER_WORD-1:0];
  wire logic [31:0]          wrPrioMask  = expandPrio(wrPrioGrant) & wrByteMask;
  wire logic                 wrGlobal    = wrFire && (wrAddr == OFF_GLOBAL_CTRL) && wrByteMask[0];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data in either order

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      wrAddr  <= '0;
      wrProt  <= '0;
      wrData  <= '0;
      wrStrb  <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wrAddr  <= {awaddr[ADDR_W-1:2], 2'h0};
        wrProt  <= awprot;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wrData <= wdata;
        wrStrb <= wstrb;
      end
      if (wrFire) begin
        bvalid <= 1'b1;
        bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global control: enables, affinity routing, security disable

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gctl <= '0;
      gctl.securityDisable <= ~TWO_STATES;
    end else if (wrGlobal) begin
      gctl.g1nsEn <= wrData[GC_G1NS];
      gctl.areNs  <= wrData[GC_ARE_NS];
      if (wrSecure) begin
        gctl.g0En <= wrData[GC_G0];
        gctl.g1sEn <= wrData[GC_G1S] & ~(singleState | wrData[GC_DS]);
        gctl.areS <= wrData[GC_ARE_S];
        gctl.securityDisable <= gctl.securityDisable | wrData[GC_DS] | ~TWO_STATES;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-interrupt configuration

  // Group assignment and grants from secure accesses only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      groupBits <= '0;
      groupMod  <= '0;
      nsAccess  <= '0;
    end else if (wrFire) begin
      if (wrAddr == OFF_GROUP) groupBits <= (groupBits & ~wrSecMask) | (wrData[NUM_INT-1:0] & wrSecMask);
      if (wrAddr == OFF_GROUP_MOD) groupMod <= (groupMod & ~wrSecMask) | (wrData[NUM_INT-1:0] & wrSecMask);
      if (wrAddr == OFF_NS_ACCESS) nsAccess <= (nsAccess & ~wrSecMask) | (wrData[NUM_INT-1:0] & wrSecMask);
    end
  end

  // Enable, trigger, routing and priority, masked per interrupt grant
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enableBits <= '0;
      trigEdge   <= '0;
      routeBits  <= '0;
      prioBits   <= '0;
    end else if (wrFire) begin
      if (wrAddr == OFF_ENABLE) enableBits <= (enableBits & ~wrIntMask) | (wrData[NUM_INT-1:0] & wrIntMask);
      if (wrAddr == OFF_TRIGGER) trigEdge <= (trigEdge & ~wrIntMask) | (wrData[NUM_INT-1:0] & wrIntMask);
      if (wrAddr == OFF_ROUTE) routeBits <= (routeBits & ~wrIntMask) | (wrData[NUM_INT-1:0] & wrIntMask);
      if (wrPrioSel) begin
        prioBits[wrPrioHi*32 +: 32] <= (prioBits[wrPrioHi*32 +: 32] & ~wrPrioMask) | (wrData & wrPrioMask);
      end
    end
  end

  // Source synchroniser and edge capture; a new edge beats a clear
  wire logic [NUM_INT-1:0] srcRise  = srcSync & ~srcPrev;
  wire logic [NUM_INT-1:0] pendClr  = (wrFire && wrAddr == OFF_PENDING) ? (wrData[NUM_INT-1:0] & wrIntMask) : '0;
  wire logic [NUM_INT-1:0] pendVec  = (trigEdge & edgePend) | (~trigEdge & srcSync);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srcMeta  <= '0;
      srcSync  <= '0;
      srcPrev  <= '0;
      edgePend <= '0;
    end else begin
      srcMeta  <= intSource;
      srcSync  <= srcMeta;
      srcPrev  <= srcSync;
      edgePend <= (edgePend & ~pendClr) | srcRise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Redistributor and CPU interface per PE

  genvar p;
  genvar i;
  generate
    for (p = 0; p < NUM_PE; p++) begin : g_pe
      wire logic       peHit   = wrFire && wrPeRegion && (wrPeIdx == PE_IDX_W'(p));
      wire logic       cpuOpen = |peCfg[p].sysreg_enable;
      wire logic       asleep  = peCfg[p].sleepReq | peCfg[p].childAsleep;
      wire logic [1:0] el      = peLevel[2*p +: 2];
      wire logic       peSec   = peSecure[p] & ~singleState;
      wire logic       lpiOk   = lpiRequest[p] && (LPI_PRIO < peCfg[p].pmr)
                                 && gctl.g1nsEn && peCfg[p].g1SigNs;
      wire logic       lpiFast = ~singleState && ((el == EL_TOP) || peSec);
      logic [NUM_INT-1:0] fastVec;
      logic [NUM_INT-1:0] normVec;

      // Configuration writes; CPU-if registers wait for system-register enable
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          peCfg[p] <= '0;
          peCfg[p].sleepReq <= 1'b1;
          peCfg[p].childAsleep <= 1'b1;
          peCfg[p].pmr <= PMR_RESET;
        end else begin
          peCfg[p].childAsleep <= peCfg[p].sleepReq;
          if (peHit && wrByteMask[0]) begin
            unique case (wrPeOff)
              PE_WAKE: peCfg[p].sleepReq <= wrData[WAKE_SLEEP];
              PE_SRE: peCfg[p].sysreg_enable <= wrData[2:0];
              PE_PMR: if (cpuOpen) peCfg[p].pmr <= wrData[7:0];
              PE_BPR: if (cpuOpen) peCfg[p].bpr <= wrData[2:0];
              PE_CTLR: if (cpuOpen) begin
                peCfg[p].completion_mode[0] <= wrData[0];
                if (wrSecure) peCfg[p].completion_mode[1] <= wrData[1];
              end
              PE_GRP0: if (cpuOpen && wrSecure) peCfg[p].g0Sig <= wrData[0];
              PE_GRP1: if (cpuOpen) begin
                if (wrSecure && ~singleState) peCfg[p].g1SigS <= wrData[0];
                else peCfg[p].g1SigNs <= wrData[0];
              end
              PE_GRP1_TOP: if (cpuOpen && wrSecure) begin
                peCfg[p].g1SigNs <= wrData[TOP_NS];
                peCfg[p].g1SigS  <= wrData[TOP_S] & ~singleState;
              end
              default: ;
            endcase
          end
        end
      end

      // Classification of each interrupt for this PE
      for (i = 0; i < NUM_INT; i++) begin : g_int
        wire logic isG0   = ~groupBits[i];
        wire logic isG1s  = groupBits[i] & groupMod[i] & ~singleState;
        wire logic isG1ns = groupBits[i] & ~isG1s;
        wire logic grpOn  = (isG0 & gctl.g0En & peCfg[p].g0Sig)
                          | (isG1s & gctl.g1sEn & peCfg[p].g1SigS)
                          | (isG1ns & gctl.g1nsEn & peCfg[p].g1SigNs);
        wire logic areOn  = secureInt[i] ? gctl.areS : gctl.areNs;
        wire logic target = ~areOn | (routeBits[i] == 1'(p));
        wire logic prioOk = {prioBits[i*PRIO_W +: PRIO_W], 4'h0} < peCfg[p].pmr;
        wire logic live   = pendVec[i] & enableBits[i] & grpOn & target & prioOk & ~asleep;
        wire logic g1Fast = ~singleState & ((el == EL_TOP) | (isG1s != peSec));
        assign fastVec[i] = live & (isG0 | g1Fast);
        assign normVec[i] = live & ~isG0 & ~g1Fast;
      end

      // Registered request lines
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          fastIrq[p]   <= 1'b0;
          normalIrq[p] <= 1'b0;
        end else begin
          fastIrq[p]   <= (|fastVec) | (lpiOk & ~asleep & lpiFast);
          normalIrq[p] <= (|normVec) | (lpiOk & ~asleep & ~lpiFast);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; per-interrupt and CPU-if secure fields hidden from ungranted non-secure reads, global control read in full

  wire logic [PE_IDX_W-1:0] rdPeIdx = araddr[PE_STRIDE_LSB +: PE_IDX_W];
  wire logic [4:0]          rdPeOff = araddr[4:0];
  wire logic [ADDR_W-1:0]   rdAddr  = {araddr[ADDR_W-1:2], 2'h0};
  wire pe_cfg_s             rdPe    = peCfg[rdPeIdx];
  logic [31:0]              readMux;

  always_comb begin
    readMux = '0;
    if (rdAddr[11:8] == PE_REGION) begin
      unique case (rdPeOff)
        PE_WAKE: begin
          readMux[WAKE_SLEEP] = rdPe.sleepReq;
          readMux[WAKE_CHILD] = rdPe.childAsleep;
        end
        PE_SRE: readMux[2:0] = rdPe.sysreg_enable;
        PE_PMR: readMux[7:0] = rdPe.pmr;
        PE_BPR: readMux[2:0] = rdPe.bpr;
        PE_CTLR: readMux[1:0] = {rdPe.completion_mode[1] & rdSecure, rdPe.completion_mode[0]};
        PE_GRP0: readMux[0] = rdPe.g0Sig & rdSecure;
        PE_GRP1: readMux[0] = (rdSecure && ~singleState) ? rdPe.g1SigS : rdPe.g1SigNs;
        PE_GRP1_TOP: readMux[1:0] = rdSecure ? {rdPe.g1SigS, rdPe.g1SigNs} : 2'h0;
        default: readMux = '0;
      endcase
    end else begin
      unique case (rdAddr)
        OFF_GLOBAL_CTRL: begin
          readMux[GC_G0]     = gctl.g0En;
          readMux[GC_G1NS]   = gctl.g1nsEn;
          readMux[GC_G1S]    = gctl.g1sEn;
          readMux[GC_ARE_S]  = gctl.areS;
          readMux[GC_ARE_NS] = gctl.areNs;
          readMux[GC_DS]     = gctl.securityDisable;
        end
        OFF_GROUP: readMux[NUM_INT-1:0] = groupBits & rdGrant;
        OFF_GROUP_MOD: readMux[NUM_INT-1:0] = groupMod & rdGrant;
        OFF_NS_ACCESS: readMux[NUM_INT-1:0] = nsAccess & {NUM_INT{rdSecure}};
        OFF_ENABLE: readMux[NUM_INT-1:0] = enableBits & rdGrant;
        OFF_PENDING: readMux[NUM_INT-1:0] = pendVec & rdGrant;
        OFF_TRIGGER: readMux[NUM_INT-1:0] = trigEdge & rdGrant;
        OFF_ROUTE: readMux[NUM_INT-1:0] = routeBits & rdGrant;
        OFF_PRIO0: readMux = prioBits[31:0] & expandPrio(rdGrant[INT_PER_WORD-1:0]);
        OFF_PRIO1: readMux = prioBits[63:32] & expandPrio(rdGrant[NUM_INT-1:INT_PER_WORD]);
        default: readMux = '0;
      endcase
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= readMux;
      rresp   <= isMapped(rdAddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ===== src/irq_security_group_pkg.sv
/*
  Constants, register map and carrier types of the interrupt security/group
  configuration block. Assumes a 100 MHz single clock and AXI4-Lite access.
*/
package irq_security_group_pkg;
  localparam int NUM_INT  = 16;
  localparam int NUM_PE   = 2;
  localparam int PE_IDX_W = 1;
  localparam int ADDR_W   = 12;
  localparam int PRIO_W   = 4;
  localparam int INT_PER_WORD = 8;

  // Global register offsets
  localparam logic [ADDR_W-1:0] OFF_GLOBAL_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_GROUP       = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_GROUP_MOD   = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_NS_ACCESS   = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_ENABLE      = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_PENDING     = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_TRIGGER     = 12'h01c;
  localparam logic [ADDR_W-1:0] OFF_ROUTE       = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_PRIO0       = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_PRIO1       = 12'h02c;
  localparam logic [3:0]        PE_REGION       = 4'h1;
  localparam int                PE_STRIDE_LSB   = 5;

  // Per-PE register offsets inside one 32-byte slot
  localparam logic [4:0] PE_WAKE     = 5'h00;
  localparam logic [4:0] PE_SRE      = 5'h04;
  localparam logic [4:0] PE_PMR      = 5'h08;
  localparam logic [4:0] PE_BPR      = 5'h0c;
  localparam logic [4:0] PE_CTLR     = 5'h10;
  localparam logic [4:0] PE_GRP0     = 5'h14;
  localparam logic [4:0] PE_GRP1     = 5'h18;
  localparam logic [4:0] PE_GRP1_TOP = 5'h1c;

  // Field positions
  localparam int GC_G0 = 0;
  localparam int GC_G1NS = 1;
  localparam int GC_G1S = 2;
  localparam int GC_ARE_S = 4;
  localparam int GC_ARE_NS = 5;
  localparam int GC_DS = 6;
  localparam int WAKE_SLEEP = 1;
  localparam int WAKE_CHILD = 2;
  localparam int TOP_NS = 0;
  localparam int TOP_S = 1;

  // Reset values and fixed figures
  localparam logic [7:0] PMR_RESET  = 8'h00;
  localparam logic [7:0] LPI_PRIO   = 8'ha0;
  localparam logic [1:0] EL_TOP     = 2'h3;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic securityDisable;
    logic areNs;
    logic areS;
    logic g1sEn;
    logic g1nsEn;
    logic g0En;
  } glbl_ctrl_s;

  typedef struct packed {
    logic       sleepReq;
    logic       childAsleep;
    logic [2:0] sysreg_enable;
    logic [7:0] pmr;
    logic [2:0] bpr;
    logic [1:0] completion_mode;
    logic       g0Sig;
    logic       g1SigNs;
    logic       g1SigS;
  } pe_cfg_s;
endpackage

// ===== sim/irq_security_group_chk.sv
/*
  Checker: bus timing and request-output assertions of the block.
  Assumes the top-module ports only, attached by the bind below.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_security_group_chk
  import irq_security_group_pkg::*;
(
  input wire logic                core_clk,
  input wire logic                rst,
  input wire logic                awvalid,
  input wire logic                awready,
  input wire logic                wvalid,
  input wire logic                wready,
  input wire logic [1:0]          bresp,
  input wire logic                bvalid,
  input wire logic                bready,
  input wire logic                arvalid,
  input wire logic                arready,
  input wire logic [31:0]         rdata,
  input wire logic                rvalid,
  input wire logic                rready,
  input wire logic [2*NUM_PE-1:0] peLevel,
  input wire logic [NUM_PE-1:0]   fastIrq,
  input wire logic [NUM_PE-1:0]   normalIrq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0] wrCnt;
  // Counts write responses, saturating
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) wrCnt <= 2'h0;
    else if (bvalid && bready && wrCnt != 2'h3) wrCnt <= wrCnt + 2'h1;
  end
  sequence bothTaken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence respTwoLater;
    ##1 !bvalid ##1 bvalid;
  endsequence
  wr_resp_a: assert property (bothTaken |-> respTwoLater)
    else $error("write response not two cycles after take");
  rd_resp_a: assert property (arvalid && arready |=> rvalid)
    else $error("read data not one cycle after take");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  busy_lock_a: assert property (bvalid |-> !awready && !wready)
    else $error("write channels open during response");
  rd_close_a: assert property (rvalid && rready |=> !rvalid && arready)
    else $error("read channel not reopened");
  sleep_quiet_a: assert property (wrCnt < 2'h3 |-> !fastIrq && !normalIrq)
    else $error("request before wake-up");
  top_fast_a: assert property (peLevel[1:0] == EL_TOP [*2] |-> !normalIrq[0])
    else $error("normal request at top level");
endmodule
bind irq_security_group irq_security_group_chk chk (.*);
`default_nettype wire

// ===== sim/pe_model.sv
/*
  Model of the processing elements: presents security state, exception
  level and message requests. Assumes modes set by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module pe_model
  import irq_security_group_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire logic [NUM_PE-1:0]   modeSec,
  input  wire logic [2*NUM_PE-1:0] modeLvl,
  input  wire logic [NUM_PE-1:0]   modeLpi,
  output logic [NUM_PE-1:0]        peSecure,
  output logic [2*NUM_PE-1:0]      peLevel,
  output logic [NUM_PE-1:0]        lpiRequest
);
  // Cores leave reset secure at the top level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      peSecure   <= '1;
      peLevel    <= {NUM_PE{EL_TOP}};
      lpiRequest <= '0;
    end else begin
      peSecure   <= modeSec;
      peLevel    <= modeLvl;
      lpiRequest <= modeLpi;
    end
  end
endmodule
`default_nettype wire

// ===== sim/irq_security_group_tb_top.sv
/*
  Bench: AXI4-Lite master, PE model, row table of request mapping, then
  gating, access, sticky and reset cases. Assumes one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module irq_security_group_tb_top
  import irq_security_group_pkg::*;
;
  logic                core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic                awready, wready, bvalid, arready, rvalid;
  logic [ADDR_W-1:0]   awaddr, araddr;
  logic [2:0]          awprot, arprot;
  logic [3:0]          wstrb;
  logic [31:0]         wdata, rdata, rd;
  logic [1:0]          bresp, rresp, rs;
  logic [NUM_INT-1:0]  intSource;
  logic [NUM_PE-1:0]   lpiRequest, peSecure, fastIrq, normalIrq, modeSec, modeLpi;
  logic [2*NUM_PE-1:0] peLevel, modeLvl;
  int                  nMismatch, numChecks, i;
  // Rows: group, modifier, PE secure, level[1:0], fast, normal
  logic [6:0]          rows [8] = '{7'h06, 7'h75, 7'h66, 7'h41, 7'h56, 7'h5e, 7'h1e, 7'h49};

  irq_security_group DUT (.*);
  pe_model PM (.*);

  ////////////////////////////////////////////////////////////////////////
  // Bus cycles and comparison
  function automatic logic [11:0] pe0(input logic [4:0] o);
    return {PE_REGION, 3'h0, o};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic ns);
    @(posedge core_clk);
    awaddr  <= a;
    wdata   <= d;
    awprot  <= {1'b0, ns, 1'b0};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdReg(input logic [11:0] a, input logic ns);
    @(posedge core_clk);
    araddr  <= a;
    arprot  <= {1'b0, ns, 1'b0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic settle;
    repeat (5) @(posedge core_clk);
  endtask
  task automatic testDone;
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #50000;
    nMismatch++;
    testDone;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, awprot, arprot, wdata, intSource} = '0;
    {modeSec, modeLvl, modeLpi} = '0;
    wstrb = 4'hf;
    rst   = 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    wr(OFF_GLOBAL_CTRL, 32'h7, 1'b0);
    wr(pe0(PE_WAKE), 32'h0, 1'b0);
    do rdReg(pe0(PE_WAKE), 1'b0); while (rd[WAKE_CHILD] !== 1'b0);
    wr(pe0(PE_SRE), 32'h7, 1'b0);
    wr(pe0(PE_PMR), 32'hff, 1'b0);
    wr(pe0(PE_GRP0), 32'h1, 1'b0);
    wr(pe0(PE_GRP1_TOP), 32'h3, 1'b0);
    wr(OFF_PRIO0, 32'h0, 1'b0);
    wr(OFF_ENABLE, 32'h1, 1'b0);
    intSource <= 16'h1;
    for (i = 0; i < 8; i++) begin
      wr(OFF_GROUP, {31'h0, rows[i][6]}, 1'b0);
      wr(OFF_GROUP_MOD, {31'h0, rows[i][5]}, 1'b0);
      modeSec <= {1'b0, rows[i][4]};
      modeLvl <= {2'h0, rows[i][3:2]};
      settle;
      chk({fastIrq[0], normalIrq[0]}, rows[i][1:0]);
    end
    // Affinity routing on for non-secure: interrupt 0 leaves PE0 for PE1, which still sleeps, so neither PE requests
    wr(OFF_ROUTE, 32'h1, 1'b0);
    wr(OFF_GLOBAL_CTRL, 32'h27, 1'b0);
    settle;
    chk(normalIrq[0], 1'b0);
    chk({fastIrq[1], normalIrq[1]}, 2'h0);
    $display("mapping rows done");
    wr(OFF_GROUP, 32'h0, 1'b1);
    rdReg(OFF_GROUP, 1'b0);
    chk(rd, 32'h1);
    wr(OFF_GROUP, 32'h0, 1'b0);
    wr(OFF_ENABLE, 32'h0, 1'b1);
    rdReg(OFF_ENABLE, 1'b0);
    chk(rd, 32'h1);
    wr(OFF_GLOBAL_CTRL, 32'h6, 1'b0);
    settle;
    chk(fastIrq[0], 1'b0);
    wr(OFF_NS_ACCESS, 32'h1, 1'b0);
    wr(OFF_ENABLE, 32'h0, 1'b1);
    rdReg(OFF_ENABLE, 1'b0);
    chk(rd, 32'h0);
    $display("access and gating done");
    modeLpi <= 2'h1;
    modeSec <= 2'h1;
    modeLvl <= 4'h1;
    settle;
    chk({fastIrq[0], normalIrq[0]}, 2'h2);
    // Non-secure access touches only its own group 1 enable copy
    wr(pe0(PE_GRP1), 32'h0, 1'b1);
    rdReg(pe0(PE_GRP1_TOP), 1'b0);
    chk(rd, 32'h2);
    settle;
    chk(fastIrq[0], 1'b0);
    wr(pe0(PE_GRP1), 32'h1, 1'b1);
    // Mask equal to the message priority blocks it
    wr(pe0(PE_PMR), 32'ha0, 1'b0);
    settle;
    chk(fastIrq[0], 1'b0);
    wr(pe0(PE_PMR), 32'hff, 1'b0);
    settle;
    chk(fastIrq[0], 1'b1);
    wr(pe0(PE_CTLR), 32'h3, 1'b1);
    rdReg(pe0(PE_CTLR), 1'b0);
    chk(rd, 32'h1);
    wr(OFF_GLOBAL_CTRL, 32'h47, 1'b0);
    wr(OFF_GLOBAL_CTRL, 32'h07, 1'b0);
    rdReg(OFF_GLOBAL_CTRL, 1'b0);
    chk(rd, 32'h43);
    settle;
    chk({fastIrq[0], normalIrq[0]}, 2'h1);
    $display("single state done");
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdReg(OFF_GLOBAL_CTRL, 1'b0);
    chk(rd, 32'h0);
    rdReg(pe0(PE_WAKE), 1'b0);
    chk(rd, 32'h6);
    rdReg(12'h004, 1'b0);
    chk(rd, 32'h0);
    chk(rs, RESP_SLVERR);
    wr(12'h004, 32'h1, 1'b0);
    chk(rs, RESP_SLVERR);
    $display("reset and unmapped done");
    testDone;
  end
endmodule
`default_nettype wire
